// ==== design/sdl_cfg.svh ====
// Constants shared by both ends of the serial latch link.
`ifndef SDL_CFG_SVH
`define SDL_CFG_SVH

`define SDL_WORD_W 12
`define SDL_ADDR_W 4
`define SDL_DATA_W 8
`define SDL_ADDR_HI 11
`define SDL_ADDR_LO 8
`define SDL_DATA_HI 7
`define SDL_DATA_LO 0
`define SDL_MSB 11
`define SDL_LAST_BIT 4'hB
`define SDL_NUM_CH 8
`define SDL_CH_FIRST 4'h1
`define SDL_CH_LAST 4'h8
`define SDL_CODE_RESET 8'h00
`define SDL_WORD_RESET 12'h000
`define SDL_SYNC_STAGES 3
`define SDL_SYS_MHZ 250
`define SDL_MAX_SHIFT_KHZ 2500
`define SDL_CLK_HALF_NS 200
`define SDL_LD_SETUP_NS 200
`define SDL_LD_HIGH_NS 100
`define SDL_LD_HOLD_NS 100
`define SDL_NS_TO_CYC(ns) (((ns) * `SDL_SYS_MHZ + 999) / 1000)
`define SDL_CLK_HALF_CYC `SDL_NS_TO_CYC(`SDL_CLK_HALF_NS)
`define SDL_LD_SETUP_CYC `SDL_NS_TO_CYC(`SDL_LD_SETUP_NS)
`define SDL_LD_HIGH_CYC `SDL_NS_TO_CYC(`SDL_LD_HIGH_NS)
`define SDL_LD_HOLD_CYC `SDL_NS_TO_CYC(`SDL_LD_HOLD_NS)
`define SDL_CNT_W 8
`define SDL_FIFO_DEPTH 2

`endif

// ==== design/sdl_pkg.sv ====
// Types and helper functions for the serial latch link.
`include "sdl_cfg.svh"

package sdl_pkg;

    typedef logic [`SDL_DATA_W-1:0] sdl_code_t;
    typedef logic [`SDL_ADDR_W-1:0] sdl_addr_t;
    typedef logic [`SDL_WORD_W-1:0] sdl_word_t;
    typedef sdl_code_t [`SDL_NUM_CH-1:0] sdl_bank_t;
    typedef logic [`SDL_NUM_CH-1:0] sdl_sel_t;

    // The address field is weighted with bit 8 highest and bit 11 lowest.
    function automatic sdl_addr_t sdl_addr_of(input sdl_word_t w);
        sdl_addr_of = {w[`SDL_ADDR_LO], w[`SDL_ADDR_LO+1],
                       w[`SDL_ADDR_LO+2], w[`SDL_ADDR_HI]};
    endfunction

    // Builds a word from a channel code and a data byte.
    function automatic sdl_word_t sdl_word_of(input sdl_addr_t a,
                                              input sdl_code_t d);
        sdl_word_of = {a[0], a[1], a[2], a[3], d};
    endfunction

    // One-hot latch select; codes outside 1 to 8 select nothing.
    function automatic sdl_sel_t sdl_decode(input sdl_addr_t a);
        sdl_decode = '0;
        if (a >= `SDL_CH_FIRST && a <= `SDL_CH_LAST)
        begin
            sdl_decode[3'(a - `SDL_CH_FIRST)] = 1'b1;
        end
    endfunction

endpackage

// ==== design/sdl_link_if.sv ====
// Pin bundle between the host and the serial latch device.
`timescale 1ns/100ps
`default_nettype none

interface sdl_link_if;
    logic shift_clk;
    logic serial_in;
    logic load_strobe;
    logic serial_out;

    modport dev (
        input shift_clk,
        input serial_in,
        input load_strobe,
        output serial_out
    );

    modport host (
        output shift_clk,
        output serial_in,
        output load_strobe,
        input serial_out
    );
endinterface

`default_nettype wire

// ==== design/sdl_device.sv ====
// Device end: shift register, address decoder and eight channel latches.
`timescale 1ns/100ps
`default_nettype none

module sdl_device
    import sdl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    sdl_link_if.dev link,
    output sdl_pkg::sdl_bank_t analog_channel_out_o,
    output sdl_pkg::sdl_addr_t load_addr_o,
    output logic write_pulse_o,
    output logic deselect_pulse_o,
    output sdl_pkg::sdl_word_t shift_word_o
);
    import sdl_pkg::*;

    localparam int PIN_N = 3;
    localparam int PIN_CLK = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_LD = 2;

    // Pins from the other party pass three flops; a change is accepted
    // only once the second and third stage agree.
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_r;
    logic [PIN_N-1:0] pin_s2_r;
    logic [PIN_N-1:0] pin_s3_r;
    logic [PIN_N-1:0] pin_flt_r;
    logic [PIN_N-1:0] pin_flt_nxt;

    assign pin_raw = {link.load_strobe, link.serial_in, link.shift_clk};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    pin_s1_r[gi] <= 1'b0;
                    pin_s2_r[gi] <= 1'b0;
                    pin_s3_r[gi] <= 1'b0;
                    pin_flt_r[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    pin_flt_r[gi] <= pin_flt_nxt[gi];
                end
            end

            assign pin_flt_nxt[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) ?
                                     pin_s3_r[gi] : pin_flt_r[gi];
        end
    endgenerate

    // The rise is taken from the filter's next value and data from its register,
    // so the data level used is the one that stood at the pin one cycle before the clock rose.
    wire clk_rise = pin_flt_nxt[PIN_CLK] & ~pin_flt_r[PIN_CLK];
    wire din_lvl = pin_flt_r[PIN_DIN];
    wire ld_lvl = pin_flt_r[PIN_LD];

    // Shift register.
    sdl_word_t shift_r;
    sdl_word_t shift_nxt;

    // Each rising edge moves the word one place toward bit 11.
    assign shift_nxt = clk_rise ?
                       {shift_r[`SDL_MSB-1:0], din_lvl} :
                       shift_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shift_r <= `SDL_WORD_RESET;
        end
        else
        begin
            shift_r <= shift_nxt;
        end
    end

    // Address and data fields of the held word.
    wire sdl_addr_t live_addr = sdl_addr_of(shift_r);
    wire sdl_code_t live_data = shift_r[`SDL_DATA_HI:`SDL_DATA_LO];

    // Address decoder register, loaded while the strobe is high.
    sdl_addr_t addr_r;
    sdl_addr_t addr_nxt;

    assign addr_nxt = ld_lvl ? live_addr : addr_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_r <= '0;
        end
        else
        begin
            addr_r <= addr_nxt;
        end
    end

    // The live field is used so the write starts in the first strobe
    // cycle; the host keeps the clock still, so it equals the capture.
    wire sdl_sel_t sel = sdl_decode(live_addr);
    wire sdl_sel_t wr_en = ld_lvl ? sel : '0;

    // Channel latches; unselected latches keep their value.
    sdl_code_t latch_r [`SDL_NUM_CH];

    generate
        for (gi = 0; gi < `SDL_NUM_CH; gi++)
        begin : g_latch
            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    latch_r[gi] <= `SDL_CODE_RESET;
                end
                else if (wr_en[gi])
                begin
                    latch_r[gi] <= live_data;
                end
            end

            // Straight binary: code n stands for n/255 of the span.
            assign analog_channel_out_o[gi] = latch_r[gi];
        end
    endgenerate

    // Strobe edge reporting for the user side.
    // A strobe held for many cycles gives a single pulse, taken from its
    // first cycle, so the user side sees one event per load.
    logic ld_prev_r;
    logic write_pulse_r;
    logic desel_pulse_r;
    wire ld_rise = ld_lvl & ~ld_prev_r;
    wire sel_none = (sel == '0);
    wire write_pulse_nxt = ld_rise & ~sel_none;
    wire desel_pulse_nxt = ld_rise & sel_none;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ld_prev_r <= 1'b0;
        end
        else
        begin
            ld_prev_r <= ld_lvl;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            write_pulse_r <= 1'b0;
        end
        else
        begin
            write_pulse_r <= write_pulse_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            desel_pulse_r <= 1'b0;
        end
        else
        begin
            desel_pulse_r <= desel_pulse_nxt;
        end
    end

    // Cascade output is the top bit of the register itself.
    assign link.serial_out = shift_r[`SDL_MSB];

    assign load_addr_o = addr_r;
    assign write_pulse_o = write_pulse_r;
    assign deselect_pulse_o = desel_pulse_r;
    assign shift_word_o = shift_r;

endmodule

`default_nettype wire

// ==== design/sdl_host.sv ====
// Host end: buffers words and shifts them out with a divided clock.
`timescale 1ns/100ps
`default_nettype none

module sdl_host
    import sdl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    sdl_link_if.host link,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire sdl_pkg::sdl_addr_t req_chan_i,
    input wire sdl_pkg::sdl_code_t req_data_i,
    input wire logic req_load_i,
    output logic busy_o,
    output sdl_pkg::sdl_word_t echo_word_o,
    output logic echo_valid_o
);
    import sdl_pkg::*;

    typedef enum logic [2:0] {
        SDL_IDLE, SDL_LOW, SDL_HIGH, SDL_SETUP, SDL_PULSE, SDL_HOLD
    } sdl_host_st_t;

    localparam int ENT_W = `SDL_WORD_W + 1;

    // Two-entry buffer: one word plus its load flag per entry.
    logic [ENT_W-1:0] fifo_r [`SDL_FIFO_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] fill_r;
    logic pop;
    wire push = req_valid_i & req_ready_o;
    wire fifo_empty = (fill_r == 2'h0);

    assign req_ready_o = (fill_r != 2'h2);

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            fill_r <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                fifo_r[wr_ptr_r] <= {req_load_i,
                                     sdl_word_of(req_chan_i, req_data_i)};
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
            begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            fill_r <= 2'(fill_r + {1'b0, push} - {1'b0, pop});
        end
    end

    // Read-back pin from the last device in the chain.
    logic so_s1_r;
    logic so_s2_r;
    logic so_s3_r;
    logic so_flt_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            so_s1_r <= 1'b0;
            so_s2_r <= 1'b0;
            so_s3_r <= 1'b0;
            so_flt_r <= 1'b0;
        end
        else
        begin
            so_s1_r <= link.serial_out;
            so_s2_r <= so_s1_r;
            so_s3_r <= so_s2_r;
            if (so_s2_r == so_s3_r)
            begin
                so_flt_r <= so_s3_r;
            end
        end
    end

    // Shift engine.
    sdl_host_st_t st_r;
    sdl_host_st_t st_nxt;
    logic [`SDL_CNT_W-1:0] cnt_r;
    logic [3:0] bit_r;
    sdl_word_t word_r;
    logic load_r;
    sdl_word_t echo_sh_r;
    sdl_word_t echo_r;
    logic echo_vld_r;

    wire half_done = (cnt_r == `SDL_CNT_W'(`SDL_CLK_HALF_CYC - 1));
    wire setup_done = (cnt_r == `SDL_CNT_W'(`SDL_LD_SETUP_CYC - 1));
    wire pulse_done = (cnt_r == `SDL_CNT_W'(`SDL_LD_HIGH_CYC - 1));
    wire hold_done = (cnt_r == `SDL_CNT_W'(`SDL_LD_HOLD_CYC - 1));
    wire last_bit = (bit_r == `SDL_LAST_BIT);
    wire rise_now = (st_r == SDL_LOW) & half_done;

    assign pop = (st_r == SDL_IDLE) & ~fifo_empty;

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            SDL_IDLE: if (pop) st_nxt = SDL_LOW;
            SDL_LOW: if (half_done) st_nxt = SDL_HIGH;
            SDL_HIGH:
            begin
                if (half_done)
                begin
                    if (!last_bit) st_nxt = SDL_LOW;
                    else if (load_r) st_nxt = SDL_SETUP;
                    else st_nxt = SDL_IDLE;
                end
            end
            SDL_SETUP: if (setup_done) st_nxt = SDL_PULSE;
            SDL_PULSE: if (pulse_done) st_nxt = SDL_HOLD;
            SDL_HOLD: if (hold_done) st_nxt = SDL_IDLE;
            default: st_nxt = SDL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= SDL_IDLE;
            cnt_r <= '0;
            bit_r <= 4'h0;
            word_r <= `SDL_WORD_RESET;
            load_r <= 1'b0;
            echo_sh_r <= `SDL_WORD_RESET;
            echo_r <= `SDL_WORD_RESET;
            echo_vld_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= (st_nxt != st_r) ? '0 : `SDL_CNT_W'(cnt_r + 1'b1);
            echo_vld_r <= 1'b0;
            if (pop)
            begin
                {load_r, word_r} <= fifo_r[rd_ptr_r];
                bit_r <= 4'h0;
            end
            if (rise_now)
            begin
                // Sample the chain output just before it moves on.
                echo_sh_r <= {echo_sh_r[`SDL_MSB-1:0], so_flt_r};
                if (last_bit)
                begin
                    echo_r <= {echo_sh_r[`SDL_MSB-1:0], so_flt_r};
                    echo_vld_r <= 1'b1;
                end
            end
            if ((st_r == SDL_HIGH) && half_done)
            begin
                // Next bit is presented at the falling edge.
                word_r <= {word_r[`SDL_MSB-1:0], 1'b0};
                bit_r <= 4'(bit_r + 1'b1);
            end
        end
    end

    // Chained devices share clock and strobe; more words before the
    // strobe push earlier ones further down the chain.
    assign link.shift_clk = (st_r == SDL_HIGH);
    assign link.serial_in = word_r[`SDL_MSB];
    assign link.load_strobe = (st_r == SDL_PULSE);
    assign busy_o = (st_r != SDL_IDLE) | ~fifo_empty;
    assign echo_word_o = echo_r;
    assign echo_valid_o = echo_vld_r;

endmodule

`default_nettype wire

// ==== tb/sdl_link_checker.sv ====
// Assertions on the wires between the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module sdl_link_checker (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic load_strobe,
    input wire logic serial_out
);
    logic clk_d_r;
    logic [15:0] hi_r, lo_r, ld_r, ago_r, rise_r;
    logic [11:0] hist_r;
    wire logic rise = shift_clk & ~clk_d_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_d_r <= 1'b0;
            hi_r <= 16'h0;
            lo_r <= 16'h0;
            ld_r <= 16'h0;
            ago_r <= 16'hFFFF;
            rise_r <= 16'h0;
            hist_r <= 12'h000;
        end
        else
        begin
            clk_d_r <= shift_clk;
            hi_r <= shift_clk ? hi_r + 16'h1 : 16'h0;
            lo_r <= shift_clk ? 16'h0 : lo_r + {15'h0, lo_r != 16'hFFFF};
            ld_r <= load_strobe ? ld_r + 16'h1 : 16'h0;
            ago_r <= rise ? 16'h0 : ago_r + {15'h0, ago_r != 16'hFFFF};
            rise_r <= load_strobe ? 16'h0 : rise_r + {15'h0, rise};
            hist_r <= rise ? {hist_r[10:0], serial_in} : hist_r;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence ld_end_s;
        $fell(load_strobe);
    endsequence
    sequence clk_rest_s;
        !shift_clk [*8];
    endsequence

    clk_high_a: assert property ($fell(shift_clk) |-> hi_r == 16'h32)
        else $error("shift clock high phase length wrong");
    clk_low_a: assert property ($rose(shift_clk) |-> lo_r >= 16'h32)
        else $error("shift clock low phase too short");
    data_hold_a: assert property (shift_clk && $past(shift_clk) |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    ld_clk_a: assert property (load_strobe |-> !shift_clk)
        else $error("clock high during strobe");
    ld_width_a: assert property (ld_end_s |-> $past(ld_r) == 16'h18)
        else $error("strobe width wrong");
    ld_setup_a: assert property ($rose(load_strobe) |-> lo_r >= 16'h32)
        else $error("strobe setup too short");
    ld_word_a: assert property ($rose(load_strobe) |-> rise_r != 16'h0 && rise_r % 16'hC == 16'h0)
        else $error("strobe not after whole words");
    ld_hold_a: assert property (ld_end_s |-> clk_rest_s)
        else $error("clock resumed too soon after strobe");
    out_bit_a: assert property ($fell(shift_clk) |-> serial_out == hist_r[11])
        else $error("serial out is not the twelfth bit back");
    out_quiet_a: assert property ($changed(serial_out) |-> ago_r <= 16'h8)
        else $error("serial out moved away from a clock rise");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the host and device ends of the serial link.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sdl_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0, req_load_i = 1'b0, req_ready_o, busy_o;
    sdl_addr_t req_chan_i = 4'h0;
    sdl_code_t req_data_i = 8'h00;
    sdl_word_t echo_word_o, sw_a, sw_b, last_w, m;
    sdl_bank_t bank_a, bank_b, exp_a, exp_b;
    int err_total = 0, tests_run = 0;
    logic echo_valid_o, wp_a, dp_a;
    sdl_addr_t la_a;
    int n_echo = 0, n_wr = 0, n_desel = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    sdl_link_if l1();
    sdl_link_if l2();
    sdl_host i_sdl_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .link(l1.host), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_chan_i(req_chan_i), .req_data_i(req_data_i),
        .req_load_i(req_load_i), .busy_o(busy_o),
        .echo_word_o(echo_word_o), .echo_valid_o(echo_valid_o));
    sdl_device i_sdl_device (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .link(l1.dev), .analog_channel_out_o(bank_a), .load_addr_o(la_a),
        .write_pulse_o(wp_a), .deselect_pulse_o(dp_a), .shift_word_o(sw_a));
    sdl_device i_sdl_device_b (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .link(l2.dev), .analog_channel_out_o(bank_b), .load_addr_o(),
        .write_pulse_o(), .deselect_pulse_o(), .shift_word_o(sw_b));
    sdl_link_checker i_sdl_link_checker (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .shift_clk(l1.shift_clk),
        .serial_in(l1.serial_in), .load_strobe(l1.load_strobe),
        .serial_out(l1.serial_out));

    // Pulse counters for the one-cycle outputs of both ends.
    always @(posedge sys_clk_i)
    begin
        n_echo <= n_echo + int'(echo_valid_o === 1'b1);
        n_wr <= n_wr + int'(wp_a === 1'b1);
        n_desel <= n_desel + int'(dp_a === 1'b1);
    end

    function automatic logic hit(input sdl_addr_t a);
        hit = (a >= 4'h1 && a <= 4'h8);
    endfunction

    function automatic sdl_word_t mk(input sdl_addr_t a, input sdl_code_t d);
        mk = {a[0], a[1], a[2], a[3], d};
    endfunction

    function automatic sdl_bank_t upd(input sdl_bank_t b, input sdl_word_t w);
        logic [3:0] a;
        a = {w[8], w[9], w[10], w[11]};
        upd = b;
        if (a >= 4'h1 && a <= 4'h8)
            upd[a - 4'h1] = w[7:0];
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d checks=%0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic push(input sdl_addr_t a, input sdl_code_t d, input logic ld);
        int n = 0;
        req_valid_i <= 1'b1;
        req_chan_i <= a;
        req_data_i <= d;
        req_load_i <= ld;
        @(posedge sys_clk_i);
        while (req_ready_o !== 1'b1 && n < 5000)
        begin
            n++;
            @(posedge sys_clk_i);
        end
        if (n == 5000)
            err_total++;
    endtask

    task automatic idle;
        int n = 0;
        req_valid_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        while (busy_o !== 1'b0 && n < 8000)
        begin
            n++;
            @(posedge sys_clk_i);
        end
        if (n == 8000)
            err_total++;
        repeat (8) @(posedge sys_clk_i);
    endtask

    task automatic word(input sdl_addr_t a, input sdl_code_t d);
        int e0 = n_echo, w0 = n_wr, d0 = n_desel;
        push(a, d, 1'b1);
        idle();
        exp_a = upd(exp_a, mk(a, d));
        chk(bank_a, exp_a);
        chk(sw_a, mk(a, d));
        chk(echo_word_o, last_w);
        chk(la_a, a);
        chk(n_wr - w0, hit(a));
        chk(n_desel - d0, !hit(a));
        chk(n_echo - e0, 1);
        last_w = mk(a, d);
    endtask

    // Second link is driven straight from the bench with a 32 ns clock.
    task automatic link2(input int n);
        sdl_word_t w;
        w = mk(4'($urandom_range(8, 1)), 8'($urandom));
        for (int i = 0; i < n; i++)
        begin
            l2.serial_in <= w[11-i];
            m = {m[10:0], w[11-i]};
            repeat (4) @(posedge sys_clk_i);
            l2.shift_clk <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            l2.shift_clk <= 1'b0;
        end
        l2.serial_in <= ~w[12-n];
        repeat (8) @(posedge sys_clk_i);
        chk(sw_b, m);
        chk(l2.serial_out, m[11]);
        l2.load_strobe <= 1'b1;
        repeat (25) @(posedge sys_clk_i);
        l2.load_strobe <= 1'b0;
        repeat (25) @(posedge sys_clk_i);
        exp_b = upd(exp_b, m);
        chk(bank_b, exp_b);
    endtask

    initial
    begin
        sdl_addr_t ca [3];
        sdl_code_t da [3];
        int e0, w0;
        l2.shift_clk = 1'b0;
        l2.serial_in = 1'b0;
        l2.load_strobe = 1'b0;
        exp_a = '0;
        exp_b = '0;
        last_w = 12'h000;
        m = 12'h000;
        void'($urandom(32'h67d1a4d9));
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(bank_a, exp_a);
        for (int a = 0; a < 16; a++)
            word(4'(a), a == 1 ? 8'h00 : a == 2 ? 8'hFF : 8'($urandom));
        repeat (6) word(4'($urandom), 8'($urandom));
        e0 = n_echo;
        w0 = n_wr;
        for (int i = 0; i < 3; i++)
        begin
            ca[i] = 4'($urandom_range(8, 1));
            da[i] = 8'($urandom);
            push(ca[i], da[i], i == 2);
        end
        req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        chk(req_ready_o, 1'b0);
        idle();
        exp_a = upd(exp_a, mk(ca[2], da[2]));
        chk(bank_a, exp_a);
        chk(echo_word_o, mk(ca[1], da[1]));
        chk(n_echo - e0, 3);
        chk(n_wr - w0, 1);
        link2(12);
        link2(4);
        complete_run();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
